// [design/hwc_pkg.sv]
// Behaviour
// - Brake field picks pin, forced, or none
// - Speed mode: analog, duty, or frequency input
// - Shared pin routes second DAC or sense output
// - Dual pin bit assigns both DAC outputs
// - Supply range code selects 15, 30, 60 V
// - Frequency duty equals measured over full-scale frequency
// - Sleep or standby (per low-power select bit) after idle input for selected time
// - Current gain retuned each millisecond when enabled
// - Voltage gain retuned each millisecond when enabled
// - Clock source: internal, watchdog oscillator, or external
// - External reference mode follows its enable bit
// - Brake style: low-side or align braking
// - External rate is 8 kHz times two^code
package hwc_pkg;
  localparam logic [7:0]  ADDR_PIN_SETUP  = 8'hA4;
  localparam logic [7:0]  ADDR_DEV_ONE    = 8'hA6;
  localparam logic [7:0]  ADDR_DEV_TWO    = 8'hA8;
  localparam logic [31:0] RESET_PIN_SETUP = 32'h00000000;
  localparam logic [31:0] RESET_DEV_ONE   = 32'h00000000;
  localparam logic [31:0] RESET_DEV_TWO   = 32'h00000000;
  // Word indices inside the store
  localparam logic [1:0]  IDX_PIN  = 2'h0;
  localparam logic [1:0]  IDX_ONE  = 2'h1;
  localparam logic [1:0]  IDX_TWO  = 2'h2;
  // Field positions (low bit)
  localparam int SPEED_MODE_LO  = 0;
  localparam int BRAKE_SRC_LO   = 2;
  localparam int BRAKE_STYLE    = 5;
  localparam int SUPPLY_LO      = 0;
  localparam int ADDR_LO        = 20;
  localparam int DUAL_PIN       = 27;
  localparam int ROUTE_LO       = 28;
  localparam int EXT_RATE_LO    = 5;
  localparam int EXT_REF_ON     = 8;
  localparam int CLK_SRC_LO     = 9;
  localparam int LP_SELECT      = 11;
  localparam int VOLT_GAIN_ON   = 12;
  localparam int CURR_GAIN_ON   = 13;
  localparam int SLEEP_TIME_LO  = 14;
  localparam int FULL_FREQ_LO   = 16;
  // Times and derived cycle counts
  localparam int CLOCK_MHZ      = 200;
  localparam int SLEEP_T0_US    = 50;
  localparam int SLEEP_T1_US    = 200;
  localparam int SLEEP_T2_MS    = 20;
  localparam int SLEEP_T3_MS    = 200;
  localparam int GAIN_PERIOD_MS = 1;
  localparam int SLEEP_CYC0     = SLEEP_T0_US * CLOCK_MHZ;
  localparam int SLEEP_CYC1     = SLEEP_T1_US * CLOCK_MHZ;
  localparam int SLEEP_CYC2     = SLEEP_T2_MS * 1000 * CLOCK_MHZ;
  localparam int SLEEP_CYC3     = SLEEP_T3_MS * 1000 * CLOCK_MHZ;
  localparam int GAIN_CYC       = GAIN_PERIOD_MS * 1000 * CLOCK_MHZ;
  localparam logic [10:0] EXT_RATE_BASE_KHZ = 11'h008;
  localparam int FREQ_BITS      = 15;
  localparam logic [15:0] DUTY_FULL = 16'h8000;
endpackage : hwc_pkg

// [design/hwc_store_if.sv]
`timescale 1ns/1ps
interface hwc_store_if;
  logic        wrEn;
  logic [1:0]  wrIdx;
  logic [31:0] wrData;
  logic [1:0]  rdIdx;
  logic [31:0] rdData;
  logic [31:0] pinWord;
  logic [31:0] oneWord;
  logic [31:0] twoWord;
  modport ctrl  (output wrEn, wrIdx, wrData, rdIdx, input rdData, pinWord, oneWord, twoWord);
  modport store (input wrEn, wrIdx, wrData, rdIdx, output rdData, pinWord, oneWord, twoWord);
endinterface : hwc_store_if

// [design/hwc_reg_store.sv]
`timescale 1ns/1ps
module hwc_reg_store
(
  // Clocking
  input wire logic    clock,
  input wire logic    rstSyncN,
  input wire logic    ce,
  // Access
  hwc_store_if.store  bus
);
  logic [31:0] words [3];

  assign bus.pinWord = words[0];
  assign bus.oneWord = words[1];
  assign bus.twoWord = words[2];

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      words[0] <= hwc_pkg::RESET_PIN_SETUP;
      words[1] <= hwc_pkg::RESET_DEV_ONE;
      words[2] <= hwc_pkg::RESET_DEV_TWO;
    end
    else if (ce && bus.wrEn && bus.wrIdx != 2'h3)
    begin
      words[bus.wrIdx] <= bus.wrData;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
      bus.rdData <= 32'h00000000;
    else if (ce)
      bus.rdData <= (bus.rdIdx == 2'h3) ? 32'h00000000 : words[bus.rdIdx];
  end
endmodule : hwc_reg_store

// [design/hwc_config_bank.sv]
`timescale 1ns/1ps
module hwc_config_bank
#(
  parameter int SLEEP_CYC0 = hwc_pkg::SLEEP_CYC0,
  parameter int SLEEP_CYC1 = hwc_pkg::SLEEP_CYC1,
  parameter int SLEEP_CYC2 = hwc_pkg::SLEEP_CYC2,
  parameter int SLEEP_CYC3 = hwc_pkg::SLEEP_CYC3,
  parameter int GAIN_CYC   = hwc_pkg::GAIN_CYC
)
(
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Host register access
  input  wire logic [7:0]  hostAddr,
  input  wire logic        hostWr,
  input  wire logic        hostRd,
  input  wire logic [31:0] hostWdata,
  output logic [31:0]      hostRdata,
  output logic             hostAck,
  // Stored address loaded after reset
  input  wire logic [6:0]  storedAddr,
  // Device inputs
  input  wire logic        brakePin,
  input  wire logic        speedBelow,
  input  wire logic [14:0] measFreq,
  input  wire logic        measStrobe,
  // Braking
  output logic             brakeActive,
  output logic             brakeAlign,
  // Speed input mode
  output logic             speedAnalog,
  output logic             speedPwm,
  output logic             speedFreq,
  output logic [15:0]      freqDuty,
  output logic             freqDutyValid,
  // Pin routing
  output logic [3:0]       sharedPinRoute,
  output logic             dualDacPins,
  // Supply range
  output logic [1:0]       supplyRange,
  output logic             supplyRangeValid,
  // Low power
  output logic             enterStandby,
  output logic             enterSleep,
  // Gain adjust ticks
  output logic             currentGainStep,
  output logic             voltageGainStep,
  // Clocking
  output logic             clkInternal,
  output logic             clkWatchdogOsc,
  output logic             clkExternal,
  output logic             externalReferenceOn,
  output logic [10:0]      externalReferenceKhz,
  // Serial target address
  output logic [6:0]       targetAddr
);
  typedef enum logic [1:0] { HWC_IDLE, HWC_DIV } hwc_div_e;

  hwc_store_if store();
  logic [1:0]  rstSync;
  logic        rstSyncN;
  logic        strapPending;
  logic        rdPend;
  logic        rdHit;
  logic [31:0] pinW;
  logic [31:0] oneW;
  logic [31:0] twoW;
  logic [31:0] idleCount;
  logic [31:0] idleLimit;
  logic [31:0] gainCount;
  hwc_div_e    divState;
  logic [15:0] divRem;
  logic [14:0] divQuot;
  logic [14:0] divMax;
  logic [3:0]  divStep;
  logic [15:0] next_rem;

  function automatic logic [1:0] addr_index(input logic [7:0] a);
    unique case (a)
      hwc_pkg::ADDR_PIN_SETUP: addr_index = hwc_pkg::IDX_PIN;
      hwc_pkg::ADDR_DEV_ONE:   addr_index = hwc_pkg::IDX_ONE;
      hwc_pkg::ADDR_DEV_TWO:   addr_index = hwc_pkg::IDX_TWO;
      default:                 addr_index = 2'h3;
    endcase
  endfunction : addr_index

  assign rstSyncN = rstSync[1];
  assign pinW     = store.pinWord;
  assign oneW     = store.oneWord;
  assign twoW     = store.twoWord;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end

  hwc_reg_store u_store
  (
    .clock    (clock),
    .rstSyncN (rstSyncN),
    .ce       (ce),
    .bus      (store.store)
  );

  // First enabled cycle after reset loads the stored address
  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
      strapPending <= 1'b1;
    else if (ce)
      strapPending <= 1'b0;
  end

  always_comb
  begin
    store.rdIdx = addr_index(hostAddr);
    if (strapPending)
    begin
      store.wrEn   = 1'b1;
      store.wrIdx  = hwc_pkg::IDX_ONE;
      store.wrData = oneW;
      store.wrData[hwc_pkg::ADDR_LO +: 7] = storedAddr;
    end
    else
    begin
      store.wrEn   = hostWr;
      store.wrIdx  = addr_index(hostAddr);
      store.wrData = hostWdata;
    end
  end

  // Read data arrive one cycle after the store register
  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      rdPend    <= 1'b0;
      rdHit     <= 1'b0;
      hostAck   <= 1'b0;
      hostRdata <= 32'h00000000;
    end
    else if (ce)
    begin
      rdPend    <= hostRd && !hostWr;
      rdHit     <= addr_index(hostAddr) != 2'h3;
      hostAck   <= rdPend || (hostWr && !strapPending);
      hostRdata <= (rdPend && rdHit) ? store.rdData : 32'h00000000;
    end
  end

  // Field decode
  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      brakeActive          <= 1'b0;
      brakeAlign           <= 1'b0;
      speedAnalog          <= 1'b0;
      speedPwm             <= 1'b0;
      speedFreq            <= 1'b0;
      sharedPinRoute       <= 4'h0;
      dualDacPins          <= 1'b0;
      supplyRange          <= 2'h0;
      supplyRangeValid     <= 1'b0;
      clkInternal          <= 1'b0;
      clkWatchdogOsc       <= 1'b0;
      clkExternal          <= 1'b0;
      externalReferenceOn  <= 1'b0;
      externalReferenceKhz <= 11'h000;
      targetAddr           <= 7'h00;
    end
    else if (ce)
    begin
      unique case (pinW[hwc_pkg::BRAKE_SRC_LO +: 2])
        2'h1:    brakeActive <= 1'b1;
        2'h2:    brakeActive <= 1'b0;
        default: brakeActive <= brakePin;
      endcase
      brakeAlign  <= pinW[hwc_pkg::BRAKE_STYLE];
      speedAnalog <= pinW[hwc_pkg::SPEED_MODE_LO +: 2] == 2'h0;
      speedPwm    <= pinW[hwc_pkg::SPEED_MODE_LO +: 2] == 2'h1;
      speedFreq   <= pinW[hwc_pkg::SPEED_MODE_LO +: 2] == 2'h3;
      sharedPinRoute <= 4'h1 << oneW[hwc_pkg::ROUTE_LO +: 2];
      dualDacPins    <= oneW[hwc_pkg::DUAL_PIN];
      supplyRange      <= oneW[hwc_pkg::SUPPLY_LO +: 2];
      supplyRangeValid <= oneW[hwc_pkg::SUPPLY_LO +: 2] != 2'h3;
      clkInternal    <= twoW[hwc_pkg::CLK_SRC_LO +: 2] == 2'h0;
      clkWatchdogOsc <= twoW[hwc_pkg::CLK_SRC_LO +: 2] == 2'h1;
      clkExternal    <= twoW[hwc_pkg::CLK_SRC_LO +: 2] == 2'h3;
      externalReferenceOn <= twoW[hwc_pkg::EXT_REF_ON];
      externalReferenceKhz <=
        hwc_pkg::EXT_RATE_BASE_KHZ << twoW[hwc_pkg::EXT_RATE_LO +: 3];
      targetAddr <= oneW[hwc_pkg::ADDR_LO +: 7];
    end
  end

  // Sleep or standby entry timer
  always_comb
  begin
    unique case (twoW[hwc_pkg::SLEEP_TIME_LO +: 2])
      2'h0: idleLimit = 32'(SLEEP_CYC0);
      2'h1: idleLimit = 32'(SLEEP_CYC1);
      2'h2: idleLimit = 32'(SLEEP_CYC2);
      2'h3: idleLimit = 32'(SLEEP_CYC3);
    endcase
  end

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      idleCount    <= 32'h00000000;
      enterStandby <= 1'b0;
      enterSleep   <= 1'b0;
    end
    else if (ce)
    begin
      if (!speedBelow)
        idleCount <= 32'h00000000;
      else if (idleCount < idleLimit)
        idleCount <= idleCount + 32'h00000001;
      enterSleep   <= speedBelow && idleCount >= idleLimit &&
                      twoW[hwc_pkg::LP_SELECT];
      enterStandby <= speedBelow && idleCount >= idleLimit &&
                      !twoW[hwc_pkg::LP_SELECT];
    end
  end

  // Millisecond gain adjust tick
  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      gainCount       <= 32'h00000000;
      currentGainStep <= 1'b0;
      voltageGainStep <= 1'b0;
    end
    else if (ce)
    begin
      if (gainCount >= 32'(GAIN_CYC - 1))
        gainCount <= 32'h00000000;
      else
        gainCount <= gainCount + 32'h00000001;
      currentGainStep <= gainCount >= 32'(GAIN_CYC - 1) &&
                         twoW[hwc_pkg::CURR_GAIN_ON];
      voltageGainStep <= gainCount >= 32'(GAIN_CYC - 1) &&
                         twoW[hwc_pkg::VOLT_GAIN_ON];
    end
  end

  // Serial divider: duty = measured / full-scale, 1.0 = DUTY_FULL
  assign next_rem = {divRem[14:0], 1'b0};

  always_ff @(posedge clock or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      divState      <= HWC_IDLE;
      divRem        <= 16'h0000;
      divQuot       <= 15'h0000;
      divMax        <= 15'h0000;
      divStep       <= 4'h0;
      freqDuty      <= 16'h0000;
      freqDutyValid <= 1'b0;
    end
    else if (ce)
    begin
      freqDutyValid <= 1'b0;
      unique case (divState)
        HWC_IDLE:
        begin
          if (measStrobe && speedFreq)
          begin
            if (measFreq >= twoW[hwc_pkg::FULL_FREQ_LO +: hwc_pkg::FREQ_BITS])
            begin
              freqDuty      <= hwc_pkg::DUTY_FULL;
              freqDutyValid <= 1'b1;
            end
            else
            begin
              divRem   <= {1'b0, measFreq};
              divMax   <= twoW[hwc_pkg::FULL_FREQ_LO +: hwc_pkg::FREQ_BITS];
              divQuot  <= 15'h0000;
              divStep  <= 4'h0;
              divState <= HWC_DIV;
            end
          end
        end
        HWC_DIV:
        begin
          if (next_rem >= {1'b0, divMax})
          begin
            divRem  <= next_rem - {1'b0, divMax};
            divQuot <= {divQuot[13:0], 1'b1};
          end
          else
          begin
            divRem  <= next_rem;
            divQuot <= {divQuot[13:0], 1'b0};
          end
          divStep <= divStep + 4'h1;
          if (divStep == 4'hE)
          begin
            freqDuty      <= {1'b0, divQuot[13:0],
                              next_rem >= {1'b0, divMax}};
            freqDutyValid <= 1'b1;
            divState      <= HWC_IDLE;
          end
        end
        default: divState <= HWC_IDLE;
      endcase
    end
  end
endmodule : hwc_config_bank

// [bench/hwc_config_bank_chk.sv]
`timescale 1ns/1ps
module hwc_config_bank_chk
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Watched signals
  input wire logic       speedBelow,
  input wire logic       speedAnalog,
  input wire logic       speedPwm,
  input wire logic       speedFreq,
  input wire logic       clkInternal,
  input wire logic       clkWatchdogOsc,
  input wire logic       clkExternal,
  input wire logic [3:0] sharedPinRoute,
  input wire logic [1:0] supplyRange,
  input wire logic       supplyRangeValid,
  input wire logic       enterStandby,
  input wire logic       enterSleep,
  input wire logic       currentGainStep,
  input wire logic       voltageGainStep,
  input wire logic       freqDutyValid
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Input back above threshold long enough for the idle count to clear
  sequence s_input_up;
    !speedBelow [*5];
  endsequence
  sequence s_gain_quiet;
    !currentGainStep [*8];
  endsequence
  a_speed_mode_excl: assert property ($onehot0({speedAnalog, speedPwm, speedFreq}))
    else $error("speed mode decode overlaps");
  a_clk_src_excl: assert property ($onehot0({clkInternal, clkWatchdogOsc, clkExternal}))
    else $error("clock source decode overlaps");
  a_route_one_hot: assert property ($onehot0(sharedPinRoute))
    else $error("shared pin route overlaps");
  a_supply_code_ok: assert property (supplyRangeValid |-> supplyRange != 2'h3)
    else $error("undefined supply code flagged valid");
  a_low_power_excl: assert property (!(enterStandby && enterSleep))
    else $error("standby and sleep both requested");
  a_idle_clears_entry: assert property (s_input_up |-> !(enterStandby || enterSleep))
    else $error("low power entry with active input");
  a_cur_gain_gap: assert property (currentGainStep |=> s_gain_quiet)
    else $error("current gain steps too close");
  a_volt_gain_gap: assert property (voltageGainStep |=> !voltageGainStep [*8])
    else $error("voltage gain steps too close");
  a_duty_one_pulse: assert property (freqDutyValid |=> !freqDutyValid)
    else $error("duty valid longer than one cycle");
endmodule : hwc_config_bank_chk

bind hwc_config_bank hwc_config_bank_chk u_chk
(
  .clock(clock), .nrst(nrst), .speedBelow(speedBelow), .speedAnalog(speedAnalog),
  .speedPwm(speedPwm), .speedFreq(speedFreq), .clkInternal(clkInternal),
  .clkWatchdogOsc(clkWatchdogOsc), .clkExternal(clkExternal),
  .sharedPinRoute(sharedPinRoute), .supplyRange(supplyRange),
  .supplyRangeValid(supplyRangeValid), .enterStandby(enterStandby),
  .enterSleep(enterSleep), .currentGainStep(currentGainStep),
  .voltageGainStep(voltageGainStep), .freqDutyValid(freqDutyValid)
);

// [bench/hwc_host_model.sv]
`timescale 1ns/1ps
module hwc_host_model
(
  // Clock
  input  wire logic        clock,
  // Register bus
  output logic [7:0]       hostAddr,
  output logic             hostWr,
  output logic             hostRd,
  output logic [31:0]      hostWdata,
  input  wire logic [31:0] hostRdata,
  input  wire logic        hostAck
);
  initial
  begin
    hostAddr  = 8'h00;
    hostWr    = 1'b0;
    hostRd    = 1'b0;
    hostWdata = 32'h00000000;
  end
  // One-cycle request pulse, then a bounded wait for the acknowledge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge clock);
    #1;
    hostAddr  = a;
    hostWdata = d;
    hostWr    = wr;
    hostRd    = !wr;
    @(posedge clock);
    #1;
    hostWr = 1'b0;
    hostRd = 1'b0;
    q      = 32'hXXXXXXXX;
    for (n = 0; n < 4 && hostAck !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (hostAck === 1'b1)
      q = hostRdata;
  endtask : xfer
endmodule : hwc_host_model

// [bench/hw_config_register_bank_tb_top.sv]
`timescale 1ns/1ps
module hw_config_register_bank_tb_top;
  localparam logic [6:0] STORED = 7'h5A;
  localparam int         SL [4] = '{8, 16, 32, 64};
  localparam int         GC     = 50;
  logic clock = 1'b0, nrst = 1'b0, brakePin = 1'b0, speedBelow = 1'b0, measStrobe = 1'b0;
  logic [14:0] measFreq = 15'h0000;
  logic [7:0] hostAddr;
  logic [31:0] hostWdata, hostRdata, q;
  logic [15:0] freqDuty;
  logic [10:0] externalReferenceKhz;
  logic [6:0] targetAddr;
  logic [3:0] sharedPinRoute;
  logic [1:0] supplyRange;
  logic hostWr, hostRd, hostAck, brakeActive, brakeAlign, speedAnalog, speedPwm, speedFreq;
  logic freqDutyValid, dualDacPins, supplyRangeValid, enterStandby, enterSleep;
  logic currentGainStep, voltageGainStep, clkInternal, clkWatchdogOsc, clkExternal;
  logic externalReferenceOn;
  logic ce = 1'b1;
  int err_count = 0, checks_done = 0, cyc = 0;

  hwc_config_bank #(.SLEEP_CYC0(SL[0]), .SLEEP_CYC1(SL[1]), .SLEEP_CYC2(SL[2]),
    .SLEEP_CYC3(SL[3]), .GAIN_CYC(GC)) u_dut
  (
    .clock(clock), .nrst(nrst), .ce(ce), .hostAddr(hostAddr), .hostWr(hostWr),
    .hostRd(hostRd), .hostWdata(hostWdata), .hostRdata(hostRdata), .hostAck(hostAck),
    .storedAddr(STORED), .brakePin(brakePin), .speedBelow(speedBelow),
    .measFreq(measFreq), .measStrobe(measStrobe), .brakeActive(brakeActive),
    .brakeAlign(brakeAlign), .speedAnalog(speedAnalog), .speedPwm(speedPwm),
    .speedFreq(speedFreq), .freqDuty(freqDuty), .freqDutyValid(freqDutyValid),
    .sharedPinRoute(sharedPinRoute), .dualDacPins(dualDacPins), .supplyRange(supplyRange),
    .supplyRangeValid(supplyRangeValid), .enterStandby(enterStandby),
    .enterSleep(enterSleep), .currentGainStep(currentGainStep),
    .voltageGainStep(voltageGainStep), .clkInternal(clkInternal),
    .clkWatchdogOsc(clkWatchdogOsc), .clkExternal(clkExternal),
    .externalReferenceOn(externalReferenceOn),
    .externalReferenceKhz(externalReferenceKhz), .targetAddr(targetAddr)
  );
  hwc_host_model u_host
  (
    .clock(clock), .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd),
    .hostWdata(hostWdata), .hostRdata(hostRdata), .hostAck(hostAck)
  );

  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // Three-way decode shared by speed mode and clock source; code 2 selects nothing
  function automatic logic [2:0] dec3(input logic [1:0] k);
    return (k == 2'h0) ? 3'h4 : (k == 2'h1) ? 3'h2 : (k == 2'h3) ? 3'h1 : 3'h0;
  endfunction : dec3

  task automatic t_reset;
    u_host.xfer(1'b0, hwc_pkg::ADDR_PIN_SETUP, 32'h0, q);
    chk(q, hwc_pkg::RESET_PIN_SETUP, "pin word reset");
    u_host.xfer(1'b0, hwc_pkg::ADDR_DEV_ONE, 32'h0, q);
    chk(q, {5'h00, STORED, 20'h00000}, "word one reset");
    chk(targetAddr, STORED, "strap address");
    u_host.xfer(1'b0, hwc_pkg::ADDR_DEV_TWO, 32'h0, q);
    chk(q, hwc_pkg::RESET_DEV_TWO, "word two reset");
    u_host.xfer(1'b0, 8'hAA, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    $display("reset test done");
  endtask : t_reset
  task automatic t_pin;
    logic [1:0] k;
    logic [31:0] w;
    for (int c = 0; c < 4; c++)
    begin
      k = 2'(c);
      w = {26'h0000000, k[0], 1'b0, k, k};
      u_host.xfer(1'b1, hwc_pkg::ADDR_PIN_SETUP, w, q);
      chk(q, 32'h0, "write acknowledged");
      for (int p = 0; p < 2; p++)
      begin
        brakePin = p[0];
        tick(3);
        chk(brakeActive, (k == 2'h1) ? 1'b1 : (k == 2'h2) ? 1'b0 : p[0], "brake");
        chk(brakeAlign, k[0], "brake style");
        chk({speedAnalog, speedPwm, speedFreq}, dec3(k), "speed mode");
      end
      u_host.xfer(1'b0, hwc_pkg::ADDR_PIN_SETUP, 32'h0, q);
      chk(q, w, "pin word readback");
    end
    $display("pin test done");
  endtask : t_pin
  task automatic t_one;
    logic [1:0] k;
    logic [31:0] w;
    for (int c = 0; c < 4; c++)
    begin
      k = 2'(c);
      w = {2'h0, k, k[0], STORED ^ 7'(c), 18'h00000, k};
      u_host.xfer(1'b1, hwc_pkg::ADDR_DEV_ONE, w, q);
      u_host.xfer(1'b0, hwc_pkg::ADDR_DEV_ONE, 32'h0, q);
      chk(q, w, "word one readback");
      chk(sharedPinRoute, 4'h1 << k, "pin route");
      chk(dualDacPins, k[0], "dual dac pins");
      chk(supplyRange, k, "supply range");
      chk(supplyRangeValid, k != 2'h3, "supply valid");
      chk(targetAddr, STORED ^ 7'(c), "target address");
    end
    $display("word one test done");
  endtask : t_one
  task automatic t_two;
    logic [2:0] m;
    logic [31:0] w;
    for (int c = 0; c < 8; c++)
    begin
      m = 3'(c);
      w = {21'h000000, m[1:0], m[0], m, 5'h00};
      u_host.xfer(1'b1, hwc_pkg::ADDR_DEV_TWO, w, q);
      u_host.xfer(1'b0, hwc_pkg::ADDR_DEV_TWO, 32'h0, q);
      chk(q, w, "word two readback");
      chk({clkInternal, clkWatchdogOsc, clkExternal}, dec3(m[1:0]), "clock source");
      chk(externalReferenceOn, m[0], "external reference");
      chk(externalReferenceKhz, 11'h008 << m, "reference rate");
    end
    $display("word two test done");
  endtask : t_two
  task automatic t_sleep;
    logic [1:0] k;
    int n;
    for (int c = 0; c < 4; c++)
    begin
      k = 2'(c);
      u_host.xfer(1'b1, hwc_pkg::ADDR_DEV_TWO, {16'h0000, k, 2'h0, k[0], 11'h000}, q);
      tick(2);
      speedBelow = 1'b1;
      for (n = 0; n < 200 && !(enterSleep || enterStandby); n++)
        tick(1);
      chk({31'h0, n >= SL[c] && n <= SL[c] + 4}, 32'h1, "idle time");
      chk(enterSleep, k[0], "sleep chosen");
      chk(enterStandby, !k[0], "standby chosen");
      speedBelow = 1'b0;
      tick(6);
      chk(enterSleep || enterStandby, 1'b0, "idle left");
    end
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_gain;
    int nc;
    int nv;
    for (int g = 0; g < 2; g++)
    begin
      u_host.xfer(1'b1, hwc_pkg::ADDR_DEV_TWO, {18'h00000, !g[0], g[0], 12'h000}, q);
      tick(2);
      nc = 0;
      nv = 0;
      repeat (3 * GC)
      begin
        nc += int'(currentGainStep === 1'b1);
        nv += int'(voltageGainStep === 1'b1);
        tick(1);
      end
      chk(nc, g ? 0 : 3, "current gain steps");
      chk(nv, g ? 3 : 0, "voltage gain steps");
    end
    $display("gain test done");
  endtask : t_gain
  task automatic t_duty;
    int n;
    u_host.xfer(1'b1, hwc_pkg::ADDR_PIN_SETUP, 32'h00000003, q);
    u_host.xfer(1'b1, hwc_pkg::ADDR_DEV_TWO, {1'b0, 15'h0100, 16'h0000}, q);
    for (int i = 0; i < 2; i++)
    begin
      tick(2);
      measFreq   = i ? 15'h0180 : 15'h0080;
      measStrobe = 1'b1;
      tick(1);
      measStrobe = 1'b0;
      for (n = 0; n < 30 && freqDutyValid !== 1'b1; n++)
        tick(1);
      chk(freqDuty, i ? 16'h8000 : 16'h4000, "frequency duty");
    end
    $display("duty test done");
  endtask : t_duty
  // Second reset reloads the stored address; low enable holds the brake output and drops a host write
  task automatic t_freeze;
    nrst = 1'b0;
    tick(3);
    nrst = 1'b1;
    tick(4);
    chk(targetAddr, STORED, "strap after second reset");
    brakePin = 1'b1;
    tick(2);
    chk(brakeActive, 1'b1, "brake follows pin");
    ce       = 1'b0;
    brakePin = 1'b0;
    u_host.xfer(1'b1, hwc_pkg::ADDR_PIN_SETUP, 32'h00000008, q);
    chk(brakeActive, 1'b1, "brake frozen");
    ce = 1'b1;
    u_host.xfer(1'b0, hwc_pkg::ADDR_PIN_SETUP, 32'h0, q);
    chk(q, hwc_pkg::RESET_PIN_SETUP, "frozen write dropped");
    chk(brakeActive, 1'b0, "brake resumes");
    $display("freeze test done");
  endtask : t_freeze

  initial
  begin
    tick(10);
    nrst = 1'b1;
    tick(4);
    t_reset();
    t_pin();
    t_one();
    t_two();
    t_sleep();
    t_gain();
    t_duty();
    t_freeze();
    give_verdict();
  end
endmodule : hw_config_register_bank_tb_top
